// ### rtl/xle_extra_lane_ctrl.sv
// Purpose: register bank for extra lane enables of transmit links A and B
// Assumes: Avalon-MM slave with one wait state per access
// Notes: lane enable and serializer outputs are registered
//
// Our own choice: the Avalon-MM register port.

`timescale 1ns/1ps
`default_nettype none

// Contract
// - bits 7..1 of a link register turn on clocks of extra lanes 1..7
// - bit 0 also powers those lanes' serializers; clear means clocks only
// - extra lanes follow the selected link mode and test pattern settings
// - extra lane bits never override the channel power-down control
// - serializer n is clocked only if lanes 0 to n-1 are enabled
// - link B has an identical register resetting to 0x00
// - powering a channel down also powers down all its link's lanes
module xle_extra_lane_ctrl
  import xle_pkg::*;
(
  input wire logic mclk, // 200 MHz clock
  input wire logic rst, // synchronous reset, high
  input wire logic [11:0] address, // byte address
  input wire logic read, // read request
  input wire logic write, // write request
  input wire logic [3:0] byteenable, // byte lanes
  input wire logic [31:0] writedata, // write data
  output logic [31:0] readdata, // read data
  output logic waitrequest, // stall
  input wire logic [7:0] link_a_mode_lanes, // lanes link A mode needs
  input wire logic [7:0] link_b_mode_lanes, // lanes link B mode needs
  output logic link_global_enable, // link enable control
  output logic [1:0] channel_power_down, // [0] channel A, [1] channel B
  output logic [XLE_MODE_W-1:0] link_mode_select, // mode for all lanes
  output logic [XLE_TEST_W-1:0] link_test_pattern_select, // test pattern
  output logic [7:0] link_a_lane_clk_on, // link A lane clocks
  output logic [7:0] link_a_ser_on, // link A serializers
  output logic [7:0] link_b_lane_clk_on, // link B lane clocks
  output logic [7:0] link_b_ser_on // link B serializers
);

  xle_state_t st;
  xle_state_t next_st;
  logic [9:0] idx;
  logic req;
  logic wr_go;
  logic [7:0] gate_clk_a;
  logic [7:0] gate_ser_a;
  logic [7:0] gate_clk_b;
  logic [7:0] gate_ser_b;

  //////////////////////////////////////////////////////////////////////////////
  // read value of any index; unmapped indices read zero
  function automatic logic [31:0] reg_value(input logic [9:0] i,
                                            input xle_state_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (i)
      XLE_IDX_GLOBAL_EN: v[0] = s.glob_en;
      XLE_IDX_MODE_SEL: v[XLE_MODE_W-1:0] = s.mode;
      XLE_IDX_TEST_SEL: v[XLE_TEST_W-1:0] = s.test;
      XLE_IDX_POWER_DOWN: v[1:0] = s.pd;
      XLE_IDX_EXTRA_A: v[7:0] = s.ext_a;
      XLE_IDX_EXTRA_B: v[7:0] = s.ext_b;
      XLE_IDX_LANE_STATUS: v = {s.ser_b, s.clk_b, s.ser_a, s.clk_a};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : reg_value

  //////////////////////////////////////////////////////////////////////////////
  // lane gating, one instance per link
  xle_lane_gate u_gate_a (
    .mode_lanes(link_a_mode_lanes),
    .extra(st.ext_a),
    .power_down(st.pd[XLE_PD_A_BIT]),
    .lane_clk(gate_clk_a),
    .lane_ser(gate_ser_a)
  );

  xle_lane_gate u_gate_b (
    .mode_lanes(link_b_mode_lanes),
    .extra(st.ext_b),
    .power_down(st.pd[XLE_PD_B_BIT]),
    .lane_clk(gate_clk_b),
    .lane_ser(gate_ser_b)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait state, answer in the second cycle
  assign idx = address[11:2];
  assign req = read | write;
  assign waitrequest = req & ~st.ack;
  // writes land on the cycle the master sees waitrequest low
  assign wr_go = write & st.ack & byteenable[0];

  // next state
  always_comb begin
    next_st = st;
    next_st.live = 1'b1;
    next_st.ack = req & ~st.ack;
    if (read & ~st.ack) begin
      next_st.rdata = reg_value(idx, st);
    end
    if (wr_go) begin
      unique case (idx)
        XLE_IDX_GLOBAL_EN: next_st.glob_en = writedata[0];
        XLE_IDX_MODE_SEL: next_st.mode = writedata[XLE_MODE_W-1:0];
        XLE_IDX_TEST_SEL: next_st.test = writedata[XLE_TEST_W-1:0];
        XLE_IDX_POWER_DOWN: next_st.pd = writedata[1:0];
        // a running link ignores changes, so lanes never glitch mid-frame
        XLE_IDX_EXTRA_A: begin
          if (!st.glob_en) next_st.ext_a = writedata[7:0];
        end
        XLE_IDX_EXTRA_B: begin
          if (!st.glob_en) next_st.ext_b = writedata[7:0];
        end
        default: next_st.live = 1'b1;
      endcase
    end
    // registered lane enables, one cycle behind the gating
    next_st.clk_a = gate_clk_a;
    next_st.ser_a = gate_ser_a;
    next_st.clk_b = gate_clk_b;
    next_st.ser_b = gate_ser_b;
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st.ack <= 1'b0;
      st.live <= 1'b0;
      st.rdata <= 32'h0000_0000;
      st.glob_en <= XLE_GLOBAL_EN_RST;
      st.pd <= XLE_PD_RST;
      st.mode <= XLE_MODE_RST;
      st.test <= XLE_TEST_RST;
      st.ext_a <= XLE_EXTRA_RST;
      st.ext_b <= XLE_EXTRA_RST;
      st.clk_a <= 8'h00;
      st.ser_a <= 8'h00;
      st.clk_b <= 8'h00;
      st.ser_b <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs; extra lanes share the link's mode and test pattern
  assign readdata = st.rdata;
  assign link_global_enable = st.glob_en;
  assign channel_power_down = st.pd;
  assign link_mode_select = st.mode;
  assign link_test_pattern_select = st.test;
  assign link_a_lane_clk_on = st.clk_a;
  assign link_a_ser_on = st.ser_a;
  assign link_b_lane_clk_on = st.clk_b;
  assign link_b_ser_on = st.ser_b;

  //////////////////////////////////////////////////////////////////////////////
  // checks on the lane outputs, the control outputs and the extra lane registers
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // link A extra lane clocks follow its register unless powered down
  AST_A_EXTRA_CLK: assert property (
    st.live |=> link_a_lane_clk_on[7:1] == ($past(st.pd[0]) ? 7'h00 :
      ($past(st.ext_a[7:1]) | $past(link_a_mode_lanes[7:1]))))
    else $error("link A extra lane clocks wrong");

  // link B extra lane clocks, same layout as link A
  AST_B_EXTRA_CLK: assert property (
    st.live |=> link_b_lane_clk_on[7:1] == ($past(st.pd[1]) ? 7'h00 :
      ($past(st.ext_b[7:1]) | $past(link_b_mode_lanes[7:1]))))
    else $error("link B extra lane clocks wrong");

  // without the serializer bit only mode lanes may transmit
  AST_A_SER_ONLY_WITH_BIT: assert property (
    (st.live && !st.ext_a[0]) |=>
      (link_a_ser_on & ~$past(link_a_mode_lanes)) == 8'h00)
    else $error("link A extra serializer on without serializer bit");

  // same for link B
  AST_B_SER_ONLY_WITH_BIT: assert property (
    (st.live && !st.ext_b[0]) |=>
      (link_b_ser_on & ~$past(link_b_mode_lanes)) == 8'h00)
    else $error("link B extra serializer on without serializer bit");

  // every extra lane with its serializer on a live link A transmits
  AST_A_FULL_SER: assert property (
    (st.live && st.ext_a == 8'hff && !st.pd[0] && link_a_mode_lanes[0]) |=>
      link_a_ser_on == 8'hff)
    else $error("link A serializers missing with every extra lane on");

  // a serializer never runs on a lane whose clock is off
  AST_SER_WITHIN_CLK: assert property (
    (link_a_ser_on & ~link_a_lane_clk_on) == 8'h00 &&
    (link_b_ser_on & ~link_b_lane_clk_on) == 8'h00)
    else $error("serializer on without its lane clock");

  // lane 0 is never an extra lane; only the link mode turns it on
  AST_LANE0_FROM_MODE: assert property (
    (st.live && st.pd == 2'h0) |=>
      (link_a_lane_clk_on[0] == $past(link_a_mode_lanes[0]) &&
       link_b_lane_clk_on[0] == $past(link_b_mode_lanes[0])))
    else $error("lane 0 clock not governed by the link mode");

  // a refused write must leave link A's register untouched
  AST_EXTRA_FROZEN_WHILE_ON: assert property (
    (write && st.glob_en && idx == XLE_IDX_EXTRA_A) |=> $stable(st.ext_a))
    else $error("extra lane register changed while link enabled");

  // and link B's as well
  AST_B_FROZEN_WHILE_ON: assert property (
    (write && st.glob_en && idx == XLE_IDX_EXTRA_B) |=> $stable(st.ext_b))
    else $error("link B extra lane register changed while link enabled");

  // global enable follows its register, gating extra lane writes
  AST_GLOBAL_EN_TRACKS: assert property (
    (wr_go && idx == XLE_IDX_GLOBAL_EN) |=>
      link_global_enable == $past(writedata[0]))
    else $error("global link enable does not follow its register");

  // mode register drives the extra lanes too
  AST_MODE_TRACKS_REG: assert property (
    (wr_go && idx == XLE_IDX_MODE_SEL) |=>
      link_mode_select == $past(writedata[XLE_MODE_W-1:0]))
    else $error("lane mode does not follow mode register");

  // test pattern register drives the extra lanes as well
  AST_TEST_TRACKS_REG: assert property (
    (wr_go && idx == XLE_IDX_TEST_SEL) |=>
      link_test_pattern_select == $past(writedata[XLE_TEST_W-1:0]))
    else $error("lane test pattern does not follow test register");

  // power-down register takes effect on the write, at any time
  AST_PD_TRACKS_REG: assert property (
    (wr_go && idx == XLE_IDX_POWER_DOWN) |=>
      channel_power_down == $past(writedata[1:0]))
    else $error("channel power-down does not follow its register");

  // channel A power-down silences every lane of link A
  AST_A_POWER_DOWN: assert property (
    st.pd[0] |=> (link_a_lane_clk_on == 8'h00 && link_a_ser_on == 8'h00))
    else $error("link A lanes on during channel power-down");

  // channel B power-down silences every lane of link B
  AST_B_POWER_DOWN: assert property (
    st.pd[1] |=> (link_b_lane_clk_on == 8'h00 && link_b_ser_on == 8'h00))
    else $error("link B lanes on during channel power-down");

  // no serializer above a lane that is off
  AST_SER_CONTIGUOUS: assert property (
    (link_a_ser_on & ~xle_chain(link_a_lane_clk_on)) == 8'h00 &&
    (link_b_ser_on & ~xle_chain(link_b_lane_clk_on)) == 8'h00)
    else $error("serializer clocked above a disabled lane");

  // reset leaves link B with no extra lanes or serializers
  AST_B_RESET_ZERO: assert property (disable iff (1'b0)
    rst |=> (st.ext_b == XLE_EXTRA_RST && link_b_ser_on == 8'h00))
    else $error("link B extra register not cleared by reset");

  //////////////////////////////////////////////////////////////////////////////
  // checks on the bus handshake
  // every request is answered on its second cycle
  AST_BUS_ANSWER: assert property (
    req |-> ##[0:1] !waitrequest)
    else $error("bus request not answered in time");

  // every request sees one wait state first
  AST_FIRST_CYCLE_WAITS: assert property (
    $rose(req) |-> waitrequest)
    else $error("bus request answered without its wait state");

  // read data stands until the next read loads it
  AST_READ_DATA_STANDS: assert property (
    !read |=> $stable(readdata))
    else $error("read data changed without a read");

  // main scenarios
  COV_A_LANE7_SER: cover property (link_a_ser_on[7]);
  COV_B_WRITE: cover property (wr_go && idx == XLE_IDX_EXTRA_B);
  COV_STATUS_READ: cover property (read && !waitrequest &&
    idx == XLE_IDX_LANE_STATUS);
  COV_REFUSED_WRITE: cover property (write && !waitrequest && st.glob_en &&
    (idx == XLE_IDX_EXTRA_A || idx == XLE_IDX_EXTRA_B));
  COV_A_POWERED_DOWN: cover property (st.pd[0] && st.ext_a != 8'h00);

endmodule : xle_extra_lane_ctrl

`default_nettype wire

// ### rtl/xle_pkg.sv
// Purpose: shared constants and state type for the extra lane control block
// Assumes: Avalon-MM word slave, register index = byte address / 4
// Notes: lane 0 of each link is governed by the link mode and the channel power-down alone

package xle_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register indices (byte address is four times the index)
  localparam logic [9:0] XLE_IDX_GLOBAL_EN = 10'h200;
  localparam logic [9:0] XLE_IDX_MODE_SEL = 10'h201;
  localparam logic [9:0] XLE_IDX_TEST_SEL = 10'h202;
  localparam logic [9:0] XLE_IDX_POWER_DOWN = 10'h209;
  localparam logic [9:0] XLE_IDX_EXTRA_A = 10'h20a;
  localparam logic [9:0] XLE_IDX_EXTRA_B = 10'h20b;
  localparam logic [9:0] XLE_IDX_LANE_STATUS = 10'h20c;

  //////////////////////////////////////////////////////////////////////////////
  // field positions and widths
  localparam int XLE_LANES = 8;
  localparam int XLE_SER_BIT = 0;
  localparam int XLE_PD_A_BIT = 0;
  localparam int XLE_PD_B_BIT = 1;
  localparam int XLE_MODE_W = 5;
  localparam int XLE_TEST_W = 4;

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] XLE_EXTRA_RST = 8'h00;
  localparam logic [1:0] XLE_PD_RST = 2'h0;
  localparam logic XLE_GLOBAL_EN_RST = 1'b0;
  localparam logic [XLE_MODE_W-1:0] XLE_MODE_RST = '0;
  localparam logic [XLE_TEST_W-1:0] XLE_TEST_RST = '0;

  // whole state of the top module
  typedef struct packed {
    logic ack;
    logic live;
    logic [31:0] rdata;
    logic glob_en;
    logic [1:0] pd;
    logic [XLE_MODE_W-1:0] mode;
    logic [XLE_TEST_W-1:0] test;
    logic [7:0] ext_a;
    logic [7:0] ext_b;
    logic [7:0] clk_a;
    logic [7:0] ser_a;
    logic [7:0] clk_b;
    logic [7:0] ser_b;
  } xle_state_t;

  // bit n is high when lanes 0 through n are all on
  function automatic logic [7:0] xle_chain(input logic [7:0] lanes);
    logic [7:0] m;
    m[0] = lanes[0];
    for (int n = 1; n < XLE_LANES; n++) begin
      m[n] = m[n-1] & lanes[n];
    end
    return m;
  endfunction : xle_chain

endpackage : xle_pkg

// ### rtl/xle_lane_gate.sv
// Purpose: per-link gating of lane clocks and serializer power
// Assumes: mode_lanes comes from the link mode decoder, lane 0 included
// Notes: purely combinational; the top registers the results

`timescale 1ns/1ps
`default_nettype none

module xle_lane_gate
  import xle_pkg::*;
(
  input wire logic [7:0] mode_lanes, // lanes the link mode needs
  input wire logic [7:0] extra, // extra lane register, bit 0 serializer
  input wire logic power_down, // channel power-down of this link
  output logic [7:0] lane_clk, // link layer clock enables
  output logic [7:0] lane_ser // serializer power enables
);

  logic [7:0] extra_lanes;
  logic [7:0] ser_req;

  //////////////////////////////////////////////////////////////////////////////
  // extra lanes add to the mode's lanes; lane 0 cannot be an extra lane
  assign extra_lanes = {extra[7:1], 1'b0};
  // serializers of extra lanes only when the serializer bit is set
  assign ser_req = mode_lanes |
    (extra[XLE_SER_BIT] ? extra_lanes : 8'h00);

  // power-down wins over everything, so extra bits cannot revive a lane
  always_comb begin
    if (power_down) begin
      lane_clk = 8'h00;
      lane_ser = 8'h00;
    end else begin
      lane_clk = mode_lanes | extra_lanes;
      // a serializer without every lower lane on gets no clock
      lane_ser = ser_req & xle_chain(lane_clk);
    end
  end

endmodule : xle_lane_gate

`default_nettype wire

// ### bench/xle_rx_model.sv
// Purpose: receiver-side view of the transmitting lanes of links A and B
// Assumes: a lane carries data only while its serializer is powered
// Notes: a receiver aligns lanes from lane 0 up, so a gap ends the group

`timescale 1ns/1ps
`default_nettype none

module xle_rx_model (
  input wire logic [7:0] ser_a, // link A serializers
  input wire logic [7:0] ser_b, // link B serializers
  output logic [3:0] up_a, // contiguous lanes seen on A
  output logic [3:0] up_b // contiguous lanes seen on B
);
  //////////////////////////////////////////////////////////////////////////////
  // count lanes from lane 0 until the first silent one
  function automatic logic [3:0] run_len(input logic [7:0] s);
    logic [3:0] k;
    k = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (s[i] && k == i[3:0]) begin
        k = k + 4'h1;
      end
    end
    return k;
  endfunction : run_len

  // both links seen at once, no clock needed for a level view
  assign up_a = run_len(ser_a);
  assign up_b = run_len(ser_b);
endmodule : xle_rx_model

`default_nettype wire

// ### bench/xle_extra_lane_ctrl_tb_top.sv
// Purpose: scenario bench for the extra lane control register bank
// Assumes: one wait state per access; lane outputs settle one edge after the write lands
// Notes: expected values are worked out by hand from the lane rules

`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module xle_extra_lane_ctrl_tb_top
  import xle_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] address = 12'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [7:0] mode_a = 8'h01;
  logic [7:0] mode_b = 8'h03;
  logic glob;
  logic [1:0] pd;
  logic [XLE_MODE_W-1:0] msel;
  logic [XLE_TEST_W-1:0] tsel;
  logic [7:0] clk_a, ser_a, clk_b, ser_b;
  logic [3:0] up_a, up_b;
  logic [31:0] q;
  int err_count = 0;
  int checked = 0;

  always #2.5 mclk = ~mclk;

  xle_extra_lane_ctrl uut (.mclk(mclk), .rst(rst), .address(address),
    .read(read), .write(write), .byteenable(4'h1), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .link_a_mode_lanes(mode_a), .link_b_mode_lanes(mode_b),
    .link_global_enable(glob), .channel_power_down(pd),
    .link_mode_select(msel), .link_test_pattern_select(tsel),
    .link_a_lane_clk_on(clk_a), .link_a_ser_on(ser_a),
    .link_b_lane_clk_on(clk_b), .link_b_ser_on(ser_b));
  xle_rx_model rx (.ser_a(ser_a), .ser_b(ser_b), .up_a(up_a), .up_b(up_b));

  //////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // one access; request held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [9:0] idx,
                      input logic [7:0] d);
    int n;
    @(posedge mclk);
    address <= {idx, 2'b00};
    write <= w;
    read <= ~w;
    writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_count++;
      results();
    end else begin
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask : xfer

  // lane outputs are registered behind the register write
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    #1;
    `CHK({clk_a, ser_a, clk_b, ser_b}, 32'h0)
    xfer(1'b0, XLE_IDX_EXTRA_B, 8'h00);
    `CHK(q, 32'h0)
    xfer(1'b0, XLE_IDX_EXTRA_A, 8'h00);
    `CHK(q, 32'h0)
  endtask : t_reset

  // clocks only on link A, then serializers too on both links
  task automatic t_lanes();
    xfer(1'b1, XLE_IDX_EXTRA_A, 8'hfe);
    settle();
    `CHK({clk_a, ser_a}, 16'hff01)
    xfer(1'b1, XLE_IDX_EXTRA_A, 8'hff);
    xfer(1'b1, XLE_IDX_EXTRA_B, 8'h0d);
    settle();
    `CHK({clk_a, ser_a, up_a}, 20'hffff8)
    `CHK({clk_b, ser_b, up_b}, 20'h0f0f4)
    xfer(1'b0, XLE_IDX_EXTRA_A, 8'h00);
    `CHK(q, 32'hff)
  endtask : t_lanes

  // a hole at lane 1 starves every serializer above it
  task automatic t_gap();
    xfer(1'b1, XLE_IDX_EXTRA_A, 8'hf5);
    settle();
    `CHK({clk_a, ser_a, up_a}, 20'hf5011)
    @(posedge mclk);
    mode_a <= 8'h0f;
    settle();
    `CHK({clk_a, ser_a, up_a}, 20'hffff8)
    @(posedge mclk);
    mode_a <= 8'h01;
    settle();
  endtask : t_gap

  // extra lane register writes while the link runs are dropped by the device
  task automatic t_refuse();
    xfer(1'b1, XLE_IDX_GLOBAL_EN, 8'h01);
    xfer(1'b1, XLE_IDX_EXTRA_A, 8'h00);
    xfer(1'b1, XLE_IDX_EXTRA_B, 8'h00);
    xfer(1'b0, XLE_IDX_EXTRA_B, 8'h00);
    `CHK(q, 32'h0d)
    xfer(1'b0, XLE_IDX_EXTRA_A, 8'h00);
    settle();
    `CHK({glob, q[7:0], clk_a}, 17'h1f5f5)
    xfer(1'b1, XLE_IDX_GLOBAL_EN, 8'h00);
  endtask : t_refuse

  // power-down wins over extra lane bits, per link
  task automatic t_power();
    xfer(1'b1, XLE_IDX_POWER_DOWN, 8'h01);
    settle();
    `CHK({clk_a, ser_a, clk_b}, 24'h00000f)
    xfer(1'b1, XLE_IDX_POWER_DOWN, 8'h02);
    settle();
    `CHK({clk_a, clk_b, ser_b}, 24'hf50000)
    xfer(1'b1, XLE_IDX_POWER_DOWN, 8'h00);
    settle();
    `CHK({clk_b, ser_b}, 16'h0f0f)
  endtask : t_power

  // mode and test settings shared by extra lanes; unmapped reads zero
  task automatic t_misc();
    xfer(1'b1, XLE_IDX_MODE_SEL, 8'h1f);
    xfer(1'b1, XLE_IDX_TEST_SEL, 8'h0a);
    settle();
    `CHK({msel, tsel}, 9'h1fa)
    xfer(1'b1, 10'h3ff, 8'h55);
    xfer(1'b0, 10'h3ff, 8'h00);
    `CHK(q, 32'h0)
    xfer(1'b0, XLE_IDX_LANE_STATUS, 8'h00);
    `CHK(q, 32'h0f0f01f5)
  endtask : t_misc

  //////////////////////////////////////////////////////////////////////////////
  // reset for five edges, then each scenario in turn
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_lanes();
    t_gap();
    t_refuse();
    t_power();
    t_misc();
    results();
  end
endmodule : xle_extra_lane_ctrl_tb_top

`default_nettype wire
